// [hw/mrr_pkg.sv]
// Purpose: shared constants and carriers for the master reset and revision block
// Assumes: 16-bit parallel control port, byte addresses, 40 MHz ref_clk
// Notes: revision code value is arbitrary
package mrr_pkg;
    localparam logic [7:0] MRR_ADDR_MASTER = 8'h00;
    localparam logic [7:0] MRR_ADDR_UNMAPPED_LO = 8'ha0;
    localparam int MRR_BIT_SOFT_RST = 0;
    localparam int MRR_BIT_FIFO_FLUSH = 1;
    localparam int MRR_BIT_MID_RESYNC = 2;
    localparam int MRR_BIT_HIGH_RESYNC = 3;
    localparam logic [3:0] MRR_CTRL_RESET = 4'h0;
    localparam logic [15:0] MRR_REG_DEFAULT = 16'h0000;
    // arbitrary revision code, no meaning beyond this design
    localparam logic [7:0] MRR_REVISION_CODE = 8'h5a;
    localparam int MRR_CLK_PERIOD_NS = 25;
    localparam int MRR_SOFT_RST_MIN_NS = 100;
    localparam int MRR_SOFT_RST_MIN_CYC =
        (MRR_SOFT_RST_MIN_NS + MRR_CLK_PERIOD_NS - 1) / MRR_CLK_PERIOD_NS;

    // host access on the control port
    typedef struct packed {
        logic cs;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } mrr_host_req_t;

    // one-cycle pulses to the framers and fifos
    typedef struct packed {
        logic fifo_flush;
        logic mid_rate_resync;
        logic high_rate_resync;
    } mrr_pulses_t;

    typedef enum logic [1:0] {
        MRR_RUN = 2'b00,
        MRR_HOLD = 2'b01
    } mrr_state_t;
endpackage

// [hw/mrr_rise_detect.sv]
// Purpose: zero-to-one edge detector for one control bit
// Assumes: level is already synchronous to ref_clk
// Notes: a held level fires only once
module mrr_rise_detect (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic level,
    output logic pulse
);
    logic prev;

    // previous value, cleared by reset so a bit set at release still fires
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign pulse = level & ~prev;
endmodule

// [hw/mrr_master_reset.sv]
// Purpose: master reset, edge-triggered resync/flush controls and revision byte
// Assumes: host port synchronous to ref_clk, read data valid cycle after rd
// Notes: global_reset feeds every other register block of the device
//
// Contract
// - soft reset forces all registers to zero; here it drives global_reset, masks the pulses and holds state at MRR_HOLD, and ctrl keeps its written value
// - transmit outputs all ones during soft reset
// - global reset is soft bit OR pin
// - bit 1 rise flushes receive demux fifos
// - bit 2 rise resyncs mid-rate framers
// - bit 3 rise resyncs high-rate framer once
// - upper byte is read-only revision code
// - addresses a0 to ff hold nothing
// - reset held while pin is low
module mrr_master_reset
    import mrr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input mrr_pkg::mrr_host_req_t host_req,
    output logic [15:0] rdata,
    output logic rdata_valid,
    output logic global_reset,
    output logic tx_all_ones,
    output mrr_pkg::mrr_pulses_t pulses,
    output mrr_pkg::mrr_state_t state
);
    import mrr_pkg::*;

    logic [3:0] ctrl;
    logic [3:0] next_ctrl;
    logic hit_master;
    logic wr_master;
    logic unmapped;
    logic soft_rst;
    logic [15:0] master_view;
    logic [15:0] next_rdata;
    logic rise_fifo;
    logic rise_mid;
    logic rise_high;
    mrr_state_t next_state;

    // address decode; the top of the map never answers with a register
    assign unmapped = host_req.addr >= MRR_ADDR_UNMAPPED_LO;
    assign hit_master = host_req.cs && !unmapped && (host_req.addr == MRR_ADDR_MASTER);
    assign wr_master = hit_master && host_req.wr;

    // only the low nibble is writable; revision byte is not stored
    assign next_ctrl = wr_master ? host_req.wdata[3:0] : ctrl;

    // the soft reset bit does not clear itself; it stays set until the host
    // writes it back to zero, so the host keeps it for the 100 ns it needs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= MRR_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign soft_rst = ctrl[MRR_BIT_SOFT_RST];
    assign global_reset = soft_rst | ~rst_b;
    assign tx_all_ones = global_reset;

    // readback view: revision high, zeros in the unused nibble
    assign master_view = {MRR_REVISION_CODE, 4'h0, ctrl};
    assign next_rdata = (host_req.cs && host_req.rd && hit_master) ? master_view : 16'h0000;

    // registered read data; unmapped reads return zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= MRR_REG_DEFAULT;
            rdata_valid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rdata_valid <= host_req.cs && host_req.rd;
        end
    end

    // edge detectors; pulses are masked while the soft reset bit stands
    mrr_rise_detect u_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .level(ctrl[MRR_BIT_FIFO_FLUSH]),
        .pulse(rise_fifo)
    );
    mrr_rise_detect u_mid (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .level(ctrl[MRR_BIT_MID_RESYNC]),
        .pulse(rise_mid)
    );
    mrr_rise_detect u_high (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .level(ctrl[MRR_BIT_HIGH_RESYNC]),
        .pulse(rise_high)
    );

    assign pulses.fifo_flush = rise_fifo & ~soft_rst;
    assign pulses.mid_rate_resync = rise_mid & ~soft_rst;
    assign pulses.high_rate_resync = rise_high & ~soft_rst;

    // visible reset state for the rest of the device
    assign next_state = soft_rst ? MRR_HOLD : MRR_RUN;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= MRR_HOLD;
        end else begin
            unique case (next_state)
                MRR_RUN: state <= MRR_RUN;
                MRR_HOLD: state <= MRR_HOLD;
                default: state <= MRR_HOLD;
            endcase
        end
    end

    // helper counter: cycles soft reset has been held
    logic [7:0] soft_cnt;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_cnt <= 8'h00;
        end else if (soft_rst) begin
            soft_cnt <= (soft_cnt == 8'hff) ? soft_cnt : soft_cnt + 8'h01;
        end else begin
            soft_cnt <= 8'h00;
        end
    end

    // checkers below watch only what this block drives or holds.
    // an edge-triggered control has two steps: a write that takes the bit
    // from zero to one, then a pulse that stands for exactly one cycle.
    // both steps are named so the per-bit properties read the same way.
    // pulses are masked while the soft reset bit stands, so every write-triggered pulse
    // property waits one cycle and needs the soft reset clear at that point.
    sequence s_write_bit(int b);
        wr_master && host_req.wdata[b] && !ctrl[b];
    endsequence

    // a pulse that is high at one sample and low at the next
    sequence s_one_cycle(p);
        p ##1 !p;
    endsequence

    chk_soft_or_pin: assert property (@(posedge ref_clk)
        global_reset == (ctrl[0] | ~rst_b)) else $error("global reset not or of sources");
    chk_tx_ones: assert property (@(posedge ref_clk) disable iff (!rst_b)
        soft_rst |-> tx_all_ones) else $error("tx not all ones in reset");
    chk_fifo_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_write_bit(1) ##1 !soft_rst |-> pulses.fifo_flush ##1 !pulses.fifo_flush)
        else $error("fifo flush pulse wrong");
    chk_mid_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_write_bit(2) ##1 !soft_rst |-> pulses.mid_rate_resync)
        else $error("mid resync missing");
    chk_high_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pulses.high_rate_resync |=> !pulses.high_rate_resync)
        else $error("high resync repeated");
    chk_rev_byte: assert property (@(posedge ref_clk) disable iff (!rst_b)
        host_req.cs && host_req.rd && hit_master |=> rdata[15:8] == MRR_REVISION_CODE)
        else $error("revision byte wrong");
    chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        host_req.cs && host_req.rd && unmapped |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_unused_nibble: assert property (@(posedge ref_clk) disable iff (!rst_b)
        rdata[7:4] == 4'h0) else $error("unused bits not zero");
    chk_hold_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
        soft_rst |=> state == MRR_HOLD) else $error("state not hold in soft reset");
    // the host owns the hold time; a short pulse would leave the device half reset
    chk_soft_count: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(soft_rst) |-> $past(soft_cnt) >= MRR_SOFT_RST_MIN_CYC - 1)
        else $error("soft reset too short");

    // second and third controls follow the same two steps as the first
    chk_mid_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_write_bit(2) ##1 !soft_rst |-> s_one_cycle(pulses.mid_rate_resync))
        else $error("mid resync not one cycle");
    chk_high_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_write_bit(3) ##1 !soft_rst |-> s_one_cycle(pulses.high_rate_resync))
        else $error("high resync missing");

    // a pulse may only follow a fresh zero-to-one change of its bit
    chk_fifo_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pulses.fifo_flush |-> ctrl[MRR_BIT_FIFO_FLUSH] && !$past(ctrl[MRR_BIT_FIFO_FLUSH]))
        else $error("fifo flush without rising edge");
    chk_high_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pulses.high_rate_resync |-> ctrl[MRR_BIT_HIGH_RESYNC]
            && !$past(ctrl[MRR_BIT_HIGH_RESYNC]))
        else $error("high resync without rising edge");

    // nothing reaches the framers or fifos while the soft reset stands
    chk_mask_soft: assert property (@(posedge ref_clk) disable iff (!rst_b)
        soft_rst |-> !pulses.fifo_flush && !pulses.mid_rate_resync && !pulses.high_rate_resync)
        else $error("pulse during soft reset");

    // a write to the master word lands in the low nibble only
    chk_write_ctrl: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_master |=> ctrl == $past(host_req.wdata[3:0]))
        else $error("control nibble not written");

    // every read is answered one cycle later, mapped or not
    chk_rd_valid: assert property (@(posedge ref_clk) disable iff (!rst_b)
        host_req.cs && host_req.rd |=> rdata_valid)
        else $error("read not answered");
    chk_idle_rdata: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !(host_req.cs && host_req.rd && hit_master) |=> rdata == 16'h0000)
        else $error("read data not zero");

    // pin reset holds everything here at default, no disable on purpose
    chk_pin_hold: assert property (@(posedge ref_clk)
        !rst_b |-> global_reset && ctrl == MRR_CTRL_RESET)
        else $error("pin reset not holding");
    chk_tx_follows: assert property (@(posedge ref_clk)
        tx_all_ones == global_reset) else $error("tx all ones not global reset");
    chk_run_state: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !soft_rst |=> state == MRR_RUN) else $error("state not run");
endmodule

// [tb/mrr_host_model.sv]
// Purpose: host processor model on the parallel control port
// Assumes: requests launched 1 ns after the rising edge
// Notes: soft reset hold time is kept by the caller
module mrr_host_model
    import mrr_pkg::*;
(
    ref_clk,
    host_req
);
    timeunit 1ns;
    timeprecision 100ps;
    input wire logic ref_clk;
    output mrr_pkg::mrr_host_req_t host_req;
    initial host_req = '0;
    // idle fields show inverted data so a decode that ignores cs is caught
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1 host_req = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        #1 host_req = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// [tb/mrr_master_reset_tb.sv]
// Purpose: self-checking bench for the master reset and revision block
// Assumes: inputs move 1 ns after the rising edge
// Notes: control bits are left clear between tests
module mrr_master_reset_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mrr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    mrr_host_req_t host_req;
    logic [15:0] rdata;
    logic rdata_valid;
    logic global_reset;
    logic tx_all_ones;
    mrr_pulses_t pulses;
    mrr_state_t state;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // 40 mhz
    always #12.5 ref_clk = ~ref_clk;
    mrr_host_model u_mrr_host_model (.ref_clk(ref_clk), .host_req(host_req));
    mrr_master_reset u_mrr_master_reset (.ref_clk(ref_clk), .rst_b(rst_b),
        .host_req(host_req), .rdata(rdata), .rdata_valid(rdata_valid),
        .global_reset(global_reset), .tx_all_ones(tx_all_ones), .pulses(pulses), .state(state));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] d, input logic [7:0] a = MRR_ADDR_MASTER);
        u_mrr_host_model.access(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        u_mrr_host_model.access(1'b0, a, 16'h0000);
        check("rdata_valid", {15'h0, rdata_valid}, 16'h0001);
        check("rdata", rdata, exp);
    endtask
    task automatic t_edges();
        logic [15:0] wd [7] = '{16'h0002, 16'h0002, 16'h000c, 16'h0008, 16'h0000, 16'h0008,
            16'hfff6};
        logic [2:0] ex [7] = '{3'b100, 3'b000, 3'b011, 3'b000, 3'b000, 3'b001, 3'b110};
        for (int i = 0; i < 7; i++) begin
            wr(wd[i]);
            check("pulse", {13'h0, pulses}, {13'h0, ex[i]});
            @(posedge ref_clk);
            #1 check("pulse_end", {13'h0, pulses}, 16'h0000);
        end
        rd_chk(MRR_ADDR_MASTER, {MRR_REVISION_CODE, 8'h06});
        wr(16'h0000);
        $display("test edges done");
    endtask
    task automatic t_soft();
        wr(16'h0001);
        @(posedge ref_clk);
        #1 check("soft_on", {12'h0, global_reset, tx_all_ones, state}, 16'h000d);
        wr(16'h000f);
        check("held_pulse", {13'h0, pulses}, 16'h0000);
        // host keeps the soft reset bit up for its minimum time
        repeat (MRR_SOFT_RST_MIN_CYC) @(posedge ref_clk);
        wr(16'h0000);
        @(posedge ref_clk);
        #1 check("soft_off", {12'h0, global_reset, tx_all_ones, state}, 16'h0000);
        $display("test soft done");
    endtask
    task automatic t_unmapped();
        logic [7:0] ad [3] = '{MRR_ADDR_UNMAPPED_LO, 8'hc2, 8'hff};
        foreach (ad[i]) begin
            wr(16'h000e, ad[i]);
            check("unmapped_pulse", {13'h0, pulses}, 16'h0000);
            rd_chk(ad[i], 16'h0000);
        end
        rd_chk(MRR_ADDR_MASTER, {MRR_REVISION_CODE, 8'h00});
        $display("test unmapped done");
    endtask
    // pin reset in mid-run clears a set control bit
    task automatic t_pin();
        wr(16'h0008);
        rst_b = 1'b0;
        @(posedge ref_clk);
        #1 check("pin_mid", {14'h0, global_reset, tx_all_ones}, 16'h0003);
        rst_b = 1'b1;
        rd_chk(MRR_ADDR_MASTER, {MRR_REVISION_CODE, 8'h00});
        check("pin_run", {14'h0, state}, {14'h0, MRR_RUN});
        $display("test pin done");
    endtask
    // main sequence: pin reset, then one task per scenario
    initial begin
        repeat (6) @(posedge ref_clk);
        check("pin_reset", {14'h0, global_reset, tx_all_ones}, 16'h0003);
        #1 rst_b = 1'b1;
        rd_chk(MRR_ADDR_MASTER, {MRR_REVISION_CODE, 8'h00});
        check("run_state", {14'h0, state}, {14'h0, MRR_RUN});
        t_edges();
        t_soft();
        t_unmapped();
        t_pin();
        summarize();
    end
    // cut a hang short; the tests need well under 300 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            summarize();
        end
    end
endmodule
